// *** verilog/slc_link_config.sv ***
// Protocol, baud and node address settings of the two-wire slave serial port.
// Assumes a framer outside delivers decoded commands and reports end of reply.
//
// Function
// - Protocol 0 ASCII_PROTOCOL_MODE, 1 RTU, 2 RTU keypad-only
// - ASCII_PROTOCOL_MODE characters: 7 data, even parity, 1 stop
// - RTU characters: 8 data, no parity, 2 stop
// - Reply to protocol change uses old protocol
// - Reply to baud change uses old baud
// - Settings writable from keypad, option, link
// - Device only answers, never starts transactions
// - RTU address 1..247; 0 is broadcast
// - ASCII_PROTOCOL_MODE address two digits, each at most 9
// - ASCII_PROTOCOL_MODE 00, and x0 with x the own tens digit, are broadcasts, not own
// - Protocol 2 refuses link access
`default_nettype none

module slc_link_config
  import slc_pkg::*;
#(
  parameter int CMD_DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Local keypad write
  input  wire logic       kp_wr,
  input  wire logic [1:0] kp_sel,
  input  wire logic [7:0] kp_data,
  // Option module write
  input  wire logic       opt_wr,
  input  wire logic [1:0] opt_sel,
  input  wire logic [7:0] opt_data,
  // Decoded link command
  input  wire logic       link_cmd_valid,
  output logic            link_cmd_ready,
  input  wire logic       link_cmd_write,
  input  wire logic [1:0] link_cmd_sel,
  input  wire logic [7:0] link_cmd_value,
  input  wire logic [7:0] link_cmd_addr,
  // Reply handshake
  output logic            reply_req,
  input  wire logic       reply_done,
  // Settings in force
  output logic [1:0]      link_protocol_select,
  output logic [2:0]      link_baud_select,
  output logic [7:0]      link_node_address,
  output logic            ascii_protocol_mode,
  output logic            link_access_enable,
  // Character format
  output logic [3:0]      char_data_bits,
  output logic            char_parity_even,
  output logic [1:0]      char_stop_bits,
  // Frame outcome pulses
  output logic            frame_accepted,
  output logic            frame_dropped
);

  ////////////////////////////////////////////////////////////////////////////
  // Address helpers

  function automatic logic addr_legal(input logic [1:0] proto, input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    if (proto == PROTO_ASCII_PROTOCOL_MODE)
    begin
      ok = (a <= ASCII_PROTOCOL_MODE_ADDR_MAX) && ((a % ASCII_PROTOCOL_MODE_RADIX) != ADDR_GLOBAL) && ((a % ASCII_PROTOCOL_MODE_RADIX) <= ASCII_PROTOCOL_MODE_DIGIT_MAX);
    end
    else
    begin
      ok = (a != ADDR_GLOBAL) && (a <= RTU_ADDR_MAX);
    end
    return ok;
  endfunction

  function automatic logic addr_bcast(input logic [1:0] proto, input logic [7:0] a, input logic [7:0] own);
    logic b;
    b = (a == ADDR_GLOBAL);
    if (proto == PROTO_ASCII_PROTOCOL_MODE)
    begin
      b = b || (((a % ASCII_PROTOCOL_MODE_RADIX) == ADDR_GLOBAL) && ((a / ASCII_PROTOCOL_MODE_RADIX) == (own / ASCII_PROTOCOL_MODE_RADIX)));
    end
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Command FIFO

  logic             cmd_valid;
  logic             cmd_pop;
  logic [CMD_W-1:0] cmd_word;
  logic             c_wr;
  logic [1:0]       c_sel;
  logic [7:0]       c_val;
  logic [7:0]       c_addr;

  slc_fifo #(
    .W     (CMD_W),
    .DEPTH (CMD_DEPTH)
  ) slc_fifo_inst (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (link_cmd_valid),
    .in_ready  (link_cmd_ready),
    .in_data   ({link_cmd_write, link_cmd_sel, link_cmd_value, link_cmd_addr}),
    .out_valid (cmd_valid),
    .out_ready (cmd_pop),
    .out_data  (cmd_word)
  );

  assign c_wr   = cmd_word[CMD_WR_BIT];
  assign c_sel  = cmd_word[CMD_SEL_LSB +: 2];
  assign c_val  = cmd_word[CMD_VAL_LSB +: 8];
  assign c_addr = cmd_word[CMD_ADDR_LSB +: 8];

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [1:0] proto;
    logic [2:0] baud;
    logic [7:0] addr;
    logic       pend_proto_v;
    logic [1:0] pend_proto;
    logic       pend_baud_v;
    logic [2:0] pend_baud;
    logic       reply_busy;
    logic       accepted;
    logic       dropped;
    logic [3:0] data_bits;
    logic       parity_even;
    logic [1:0] stop_bits;
  } slc_state_t;

  slc_state_t st;
  slc_state_t next_st;
  logic       c_bcast;
  logic       c_match;

  // Commands are held back while a reply is in flight
  assign cmd_pop = cmd_valid && !st.reply_busy;
  assign c_bcast = addr_bcast(st.proto, c_addr, st.addr);
  assign c_match = c_bcast || (c_addr == st.addr);

  always_comb
  begin
    next_st          = st;
    next_st.accepted = 1'b0;
    next_st.dropped  = 1'b0;
    // Staged link values land once the reply is out
    if (st.reply_busy && reply_done)
    begin
      next_st.reply_busy = 1'b0;
      if (st.pend_proto_v)
      begin
        next_st.proto = st.pend_proto;
      end
      if (st.pend_baud_v)
      begin
        next_st.baud = st.pend_baud;
      end
      next_st.pend_proto_v = 1'b0;
      next_st.pend_baud_v  = 1'b0;
    end
    if (cmd_pop)
    begin
      if (st.proto == PROTO_LCD || !c_match)
      begin
        next_st.dropped = 1'b1;
      end
      else
      begin
        next_st.accepted   = 1'b1;
        next_st.reply_busy = !c_bcast;
        if (c_wr && c_sel == SEL_PROTO && c_val <= 8'(PROTO_MAX))
        begin
          if (c_bcast)
          begin
            next_st.proto = c_val[1:0];
          end
          else
          begin
            next_st.pend_proto_v = 1'b1;
            next_st.pend_proto   = c_val[1:0];
          end
        end
        if (c_wr && c_sel == SEL_BAUD)
        begin
          if (c_bcast)
          begin
            next_st.baud = c_val[2:0];
          end
          else
          begin
            next_st.pend_baud_v = 1'b1;
            next_st.pend_baud   = c_val[2:0];
          end
        end
        if (c_wr && c_sel == SEL_ADDR && addr_legal(st.proto, c_val))
        begin
          next_st.addr = c_val;
        end
      end
    end
    // Option module, then keypad; the keypad wins a tie
    if (opt_wr && opt_sel == SEL_PROTO && opt_data <= 8'(PROTO_MAX))
    begin
      next_st.proto = opt_data[1:0];
    end
    if (opt_wr && opt_sel == SEL_BAUD)
    begin
      next_st.baud = opt_data[2:0];
    end
    if (opt_wr && opt_sel == SEL_ADDR && addr_legal(st.proto, opt_data))
    begin
      next_st.addr = opt_data;
    end
    if (kp_wr && kp_sel == SEL_PROTO && kp_data <= 8'(PROTO_MAX))
    begin
      next_st.proto = kp_data[1:0];
    end
    if (kp_wr && kp_sel == SEL_BAUD)
    begin
      next_st.baud = kp_data[2:0];
    end
    if (kp_wr && kp_sel == SEL_ADDR && addr_legal(st.proto, kp_data))
    begin
      next_st.addr = kp_data;
    end
    // Framing follows the protocol in force
    if (next_st.proto == PROTO_ASCII_PROTOCOL_MODE)
    begin
      next_st.data_bits   = ASCII_PROTOCOL_MODE_DATA_BITS;
      next_st.parity_even = 1'b1;
      next_st.stop_bits   = ASCII_PROTOCOL_MODE_STOP_BITS;
    end
    else
    begin
      next_st.data_bits   = RTU_DATA_BITS;
      next_st.parity_even = 1'b0;
      next_st.stop_bits   = RTU_STOP_BITS;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st             <= '0;
      st.proto       <= PROTO_RESET;
      st.baud        <= BAUD_RESET;
      st.addr        <= ADDR_RESET;
      st.data_bits   <= RTU_DATA_BITS;
      st.stop_bits   <= RTU_STOP_BITS;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign reply_req            = st.reply_busy;
  assign link_protocol_select = st.proto;
  assign link_baud_select     = st.baud;
  assign link_node_address    = st.addr;
  assign ascii_protocol_mode  = (st.proto == PROTO_ASCII_PROTOCOL_MODE);
  assign link_access_enable   = (st.proto != PROTO_LCD);
  assign char_data_bits       = st.data_bits;
  assign char_parity_even     = st.parity_even;
  assign char_stop_bits       = st.stop_bits;
  assign frame_accepted       = st.accepted;
  assign frame_dropped        = st.dropped;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_proto_range: assert property (@(posedge clock) disable iff (!rst_n) st.proto <= PROTO_MAX)
    else $error("protocol select out of range");

  chk_ascii_protocol_mode_format: assert property (@(posedge clock) disable iff (!rst_n)
    st.proto == PROTO_ASCII_PROTOCOL_MODE |-> st.data_bits == 4'h7 && st.parity_even && st.stop_bits == 2'h1)
    else $error("ASCII_PROTOCOL_MODE framing wrong");

  chk_rtu_format: assert property (@(posedge clock) disable iff (!rst_n)
    st.proto != PROTO_ASCII_PROTOCOL_MODE |-> st.data_bits == 4'h8 && !st.parity_even && st.stop_bits == 2'h2)
    else $error("RTU framing wrong");

  chk_reply_old_proto: assert property (@(posedge clock) disable iff (!rst_n)
    (st.reply_busy && !reply_done || cmd_pop && !c_bcast) && !kp_wr && !opt_wr |=> $stable(st.proto))
    else $error("protocol changed during reply");

  chk_reply_old_baud: assert property (@(posedge clock) disable iff (!rst_n)
    (st.reply_busy && !reply_done || cmd_pop && !c_bcast) && !kp_wr && !opt_wr |=> $stable(st.baud))
    else $error("baud changed during reply");

  chk_keypad_write: assert property (@(posedge clock) disable iff (!rst_n)
    kp_wr && kp_sel == SEL_BAUD |=> st.baud == 3'($past(kp_data)))
    else $error("keypad baud write lost");

  chk_slave_only: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(st.reply_busy) |-> $past(cmd_pop) && $past(c_match))
    else $error("reply without request");

  chk_rtu_addr: assert property (@(posedge clock) disable iff (!rst_n)
    !$stable(st.addr) && $stable(st.proto) && st.proto != PROTO_ASCII_PROTOCOL_MODE |-> st.addr != 8'h00 && st.addr <= 8'hf7)
    else $error("illegal RTU address stored");

  chk_ascii_protocol_mode_addr: assert property (@(posedge clock) disable iff (!rst_n)
    !$stable(st.addr) && $stable(st.proto) && st.proto == PROTO_ASCII_PROTOCOL_MODE |-> st.addr <= 8'h63 && (st.addr % 8'h0a) != 8'h00)
    else $error("illegal ASCII_PROTOCOL_MODE address stored");

  chk_lcd_refuse: assert property (@(posedge clock) disable iff (!rst_n)
    cmd_pop && st.proto == PROTO_LCD |=> frame_dropped && !st.reply_busy)
    else $error("link access in keypad-only mode");

  chk_bcast_silent: assert property (@(posedge clock) disable iff (!rst_n)
    cmd_pop && c_bcast |=> !st.reply_busy)
    else $error("reply to broadcast");

  chk_apply_after: assert property (@(posedge clock) disable iff (!rst_n)
    st.reply_busy && reply_done && st.pend_proto_v && !kp_wr && !opt_wr |=> st.proto == $past(st.pend_proto))
    else $error("staged protocol not applied");

endmodule

`default_nettype wire

// *** verilog/slc_pkg.sv ***
// Constants shared by the serial link configuration block and its command FIFO.
// Assumes a single 100 MHz clock domain with a synchronous active-low reset.
`default_nettype none

package slc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Protocol select codes
  localparam logic [1:0] PROTO_ASCII_PROTOCOL_MODE     = 2'h0;
  localparam logic [1:0] PROTO_RTU      = 2'h1;
  localparam logic [1:0] PROTO_LCD      = 2'h2;
  localparam logic [1:0] PROTO_MAX      = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values of the three settings
  localparam logic [1:0] PROTO_RESET    = 2'h1;
  localparam logic [2:0] BAUD_RESET     = 3'h6;
  localparam logic [7:0] ADDR_RESET     = 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Setting selector carried by every write
  localparam logic [1:0] SEL_PROTO      = 2'h0;
  localparam logic [1:0] SEL_BAUD       = 2'h1;
  localparam logic [1:0] SEL_ADDR       = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Character framing
  localparam logic [3:0] ASCII_PROTOCOL_MODE_DATA_BITS = 4'h7;
  localparam logic [1:0] ASCII_PROTOCOL_MODE_STOP_BITS = 2'h1;
  localparam logic [3:0] RTU_DATA_BITS  = 4'h8;
  localparam logic [1:0] RTU_STOP_BITS  = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Node addressing
  localparam logic [7:0] ADDR_GLOBAL    = 8'h00;
  localparam logic [7:0] RTU_ADDR_MAX   = 8'hf7;
  localparam logic [7:0] ASCII_PROTOCOL_MODE_ADDR_MAX  = 8'h63;
  localparam logic [7:0] ASCII_PROTOCOL_MODE_DIGIT_MAX = 8'h09;
  localparam logic [7:0] ASCII_PROTOCOL_MODE_RADIX     = 8'h0a;

  ////////////////////////////////////////////////////////////////////////////
  // Link command word: {is_write, selector, value, frame address}
  localparam int CMD_W        = 19;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_VAL_LSB  = 8;
  localparam int CMD_SEL_LSB  = 16;
  localparam int CMD_WR_BIT   = 18;
  localparam int FIFO_DEPTH   = 8;

endpackage

`default_nettype wire

// *** verilog/slc_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides, show-ahead output.
// Assumes one clock; reset empties it.
`default_nettype none

module slc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wr_ptr;
    logic [PW-1:0]           rd_ptr;
    logic [CW-1:0]           count;
  } slc_fifo_state_t;

  slc_fifo_state_t st;
  slc_fifo_state_t next_st;
  logic            push;
  logic            pop;

  assign in_ready  = (st.count != FULL_CNT);
  assign out_valid = (st.count != '0);
  assign out_data  = st.mem[st.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.mem[st.wr_ptr] = in_data;
      next_st.wr_ptr = (st.wr_ptr == LAST_PTR) ? '0 : st.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_st.rd_ptr = (st.rd_ptr == LAST_PTR) ? '0 : st.rd_ptr + 1'b1;
    end
    if (push && !pop)
    begin
      next_st.count = st.count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule

`default_nettype wire

// *** bench/slc_reply_model.sv ***
// Far-side reply framer: answers each reply request after a set delay.
// Assumes the bench drives the delay; drives reply_done at falling edges.
`default_nettype none

module slc_reply_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Reply handshake
  input  wire logic       reply_req,
  output logic            reply_done,
  // Control and status
  input  wire logic [7:0] delay,
  output logic [7:0]      replies
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    reply_done = 1'b0;
    replies    = 8'h00;
    forever
    begin
      @(negedge clock);
      // Only answers what the device asks for
      if (rst_n === 1'b1 && reply_req === 1'b1)
      begin
        repeat (delay) @(negedge clock);
        reply_done = 1'b1;
        replies    = replies + 8'h01;
        @(negedge clock);
        reply_done = 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// *** bench/slc_link_config_bench.sv ***
// Bench for the link configuration block: local writes, link frames, replies.
// Assumes slc_pkg and the reply model are compiled first.
`default_nettype none

module slc_link_config_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import slc_pkg::*;

  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic       kp_wr = 1'b0, opt_wr = 1'b0, lc_valid = 1'b0, lc_write = 1'b0;
  logic [1:0] kp_sel = 2'h0, opt_sel = 2'h0, lc_sel = 2'h0, proto;
  logic [7:0] kp_data = 8'h00, opt_data = 8'h00, lc_value = 8'h00, lc_addr = 8'h00;
  logic [7:0] delay = 8'h01, replies, addr;
  logic [2:0] baud;
  logic [3:0] dbits;
  logic [1:0] sbits;
  logic       lc_ready, reply_req, reply_done, ascii, access, parity, acc_p, drp_p;
  int         failures = 0, tests_run = 0, acc = 0, drp = 0, cycles = 0;

  always #5 clock = ~clock;

  slc_link_config slc_link_config_inst (
    .clock(clock), .rst_n(rst_n),
    .kp_wr(kp_wr), .kp_sel(kp_sel), .kp_data(kp_data),
    .opt_wr(opt_wr), .opt_sel(opt_sel), .opt_data(opt_data),
    .link_cmd_valid(lc_valid), .link_cmd_ready(lc_ready), .link_cmd_write(lc_write),
    .link_cmd_sel(lc_sel), .link_cmd_value(lc_value), .link_cmd_addr(lc_addr),
    .reply_req(reply_req), .reply_done(reply_done),
    .link_protocol_select(proto), .link_baud_select(baud), .link_node_address(addr),
    .ascii_protocol_mode(ascii), .link_access_enable(access),
    .char_data_bits(dbits), .char_parity_even(parity), .char_stop_bits(sbits),
    .frame_accepted(acc_p), .frame_dropped(drp_p)
  );

  slc_reply_model slc_reply_model_inst (
    .clock(clock), .rst_n(rst_n), .reply_req(reply_req), .reply_done(reply_done),
    .delay(delay), .replies(replies)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pulse counters and hang guard
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (acc_p === 1'b1) acc <= acc + 1;
    if (drp_p === 1'b1) drp <= drp + 1;
    if (cycles == 8000)
    begin
      failures = failures + 1;
      final_report();
    end
  end

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic local_write(input bit opt, input logic [1:0] sel, input logic [7:0] data);
    @(negedge clock);
    if (opt) {opt_wr, opt_sel, opt_data} = {1'b1, sel, data};
    else {kp_wr, kp_sel, kp_data} = {1'b1, sel, data};
    @(negedge clock);
    {kp_wr, opt_wr} = 2'b00;
    @(negedge clock);
  endtask

  // Holds the frame until an edge samples ready high
  task automatic push(input logic wr, input logic [1:0] sel, input logic [7:0] val, input logic [7:0] a);
    logic r;
    @(negedge clock);
    {lc_valid, lc_write, lc_sel, lc_value, lc_addr} = {1'b1, wr, sel, val, a};
    do
    begin
      r = lc_ready;
      @(posedge clock);
    end while (r !== 1'b1);
    @(negedge clock);
    lc_valid = 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic wait_replies(input logic [7:0] n);
    for (int i = 0; i < 3000 && replies !== n; i++) @(negedge clock);
    idle(3);
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    idle(1);
    check("proto", PROTO_RESET, 8'(proto));
    check("baud", BAUD_RESET, 8'(baud));
    check("addr", ADDR_RESET, addr);
    check("format", 8'h82, {dbits, parity, 1'b0, sbits});
    check("modes", 8'h01, {6'h0, ascii, access});
    end_test("reset");

    local_write(0, SEL_BAUD, 8'h03);
    check("kp baud", 8'h03, 8'(baud));
    local_write(1, SEL_BAUD, 8'h07);
    check("opt baud", 8'h07, 8'(baud));
    // Keypad and option write baud in one cycle
    @(negedge clock);
    {kp_wr, opt_wr} = 2'b11;
    @(negedge clock);
    {kp_wr, opt_wr} = 2'b00;
    idle(1);
    check("kp beats opt", 8'h03, 8'(baud));
    local_write(1, SEL_ADDR, 8'h05);
    check("opt addr", 8'h05, addr);
    local_write(0, SEL_PROTO, 8'h03);
    check("bad proto", 8'h01, 8'(proto));
    end_test("local");

    delay = 8'd20;
    push(1, SEL_BAUD, 8'h02, 8'h05);
    for (int i = 0; i < 50 && reply_req !== 1'b1; i++) @(negedge clock);
    check("baud held", 8'h03, 8'(baud));
    wait_replies(8'd1);
    check("baud new", 8'h02, 8'(baud));
    push(1, SEL_PROTO, PROTO_ASCII_PROTOCOL_MODE, 8'h05);
    for (int i = 0; i < 50 && reply_req !== 1'b1; i++) @(negedge clock);
    check("proto held", 8'h01, 8'(proto));
    check("rtu fmt", 8'h82, {dbits, parity, 1'b0, sbits});
    wait_replies(8'd2);
    check("proto new", 8'h00, 8'(proto));
    check("ascii_protocol_mode fmt", 8'h79, {dbits, parity, 1'b0, sbits});
    check("ascii", 8'h01, 8'(ascii));
    end_test("link change");

    delay = 8'd1;
    local_write(0, SEL_ADDR, 8'd20);
    local_write(0, SEL_ADDR, 8'd100);
    check("ascii_protocol_mode bad addr", 8'h05, addr);
    local_write(0, SEL_ADDR, 8'd23);
    check("ascii_protocol_mode addr", 8'd23, addr);
    push(1, SEL_ADDR, 8'd24, 8'd20);
    push(0, SEL_PROTO, 8'h00, ADDR_GLOBAL);
    push(0, SEL_PROTO, 8'h00, 8'd45);
    push(0, SEL_PROTO, 8'h00, 8'd30);
    idle(6);
    check("group bcast", 8'd24, addr);
    check("accepted", 8'd4, 8'(acc));
    check("dropped", 8'd2, 8'(drp));
    check("replies", 8'd2, replies);
    end_test("ascii_protocol_mode address");

    local_write(0, SEL_PROTO, PROTO_RTU);
    local_write(0, SEL_ADDR, 8'h00);
    local_write(0, SEL_ADDR, 8'hf8);
    check("rtu bad addr", 8'd24, addr);
    local_write(0, SEL_ADDR, RTU_ADDR_MAX);
    check("rtu addr", RTU_ADDR_MAX, addr);
    end_test("rtu address");

    local_write(0, SEL_PROTO, PROTO_LCD);
    check("access", 8'h00, 8'(access));
    push(0, SEL_PROTO, 8'h00, RTU_ADDR_MAX);
    push(1, SEL_PROTO, PROTO_RTU, RTU_ADDR_MAX);
    idle(6);
    check("locked drops", 8'd4, 8'(drp));
    check("locked proto", 8'h02, 8'(proto));
    check("locked replies", 8'd2, replies);
    local_write(1, SEL_PROTO, PROTO_RTU);
    end_test("keypad lock");

    delay = 8'd100;
    repeat (9) push(0, SEL_BAUD, 8'h00, RTU_ADDR_MAX);
    check("fifo full", 8'h00, 8'(lc_ready));
    wait_replies(8'd11);
    check("fifo acc", 8'd13, 8'(acc));
    check("fifo replies", 8'd11, replies);
    check("fifo empty", 8'h01, 8'(lc_ready));
    end_test("fifo");

    // Reset while a staged protocol waits for its reply
    push(1, SEL_PROTO, PROTO_ASCII_PROTOCOL_MODE, RTU_ADDR_MAX);
    for (int i = 0; i < 50 && reply_req !== 1'b1; i++) @(negedge clock);
    check("staged req", 8'h01, 8'(reply_req));
    rst_n = 1'b0;
    idle(2);
    rst_n = 1'b1;
    idle(1);
    check("rst addr", ADDR_RESET, addr);
    check("rst reply", 8'h00, 8'(reply_req));
    check("rst ready", 8'h01, 8'(lc_ready));
    wait_replies(8'd12);
    check("rst proto", PROTO_RESET, 8'(proto));
    check("rst ascii", 8'h00, 8'(ascii));
    end_test("mid reset");
    final_report();
  end
endmodule

`default_nettype wire
